// file: core/crg_pkg.sv
// Package of constants and types for the count run/gate control block
package crg_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   // Least run pulse width when stretching is on, in microseconds
   localparam int RUN_MIN_US = 10;
   localparam int RUN_MIN_CYC = (RUN_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least start/stop pulse width the source keeps, in ns
   localparam int PULSE_MIN_NS = 100;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int MEM_DEPTH_8CH = 30000;
   localparam int MEM_DEPTH_16CH = 15000;
   localparam int MAX_SESSIONS = 8;
   localparam logic [15:0] PORT_RESET = 16'h1E61;
   localparam logic [7:0] ASCII_CR = 8'h0D;
   localparam logic [7:0] ASCII_LF = 8'h0A;
   localparam logic [7:0] ASCII_0 = 8'h30;
   localparam logic [7:0] ASCII_9 = 8'h39;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CRG_MODE_PLAIN = 2'b00,
      CRG_MODE_GDATA = 2'b01,
      CRG_MODE_GEDGE = 2'b10
   } crg_mode_t;

   // Decoded host command, one-cycle strobes
   typedef struct packed {
      logic start;
      logic stop;
      logic restart;
      logic dl_begin;
      logic dl_end;
      logic port_set;
      logic port_query;
   } crg_cmd_t;

   // Inversion switches for each control signal
   typedef struct packed {
      logic start;
      logic stop;
      logic gate;
      logic run;
   } crg_inv_t;

endpackage

// file: core/crg_top.sv
// Run/gate control, sample capture strobe and host command arbitration
//
// Summary of operation
// RQ1: Start input edge begins counting
// RQ2: Stop input edge ends counting
// RQ3: Count interval spans start to stop
// RQ4: Source holds pulses over 100 ns
// RQ5: Host start command acts like start input
// RQ6: Gate low pauses counting, high resumes
// RQ7: Open gate pin reads as high
// RQ8: Gate fall stores one memory entry
// RQ9: Memory holds 30000 or 15000 entries
// RQ10: Edge mode keeps counting while gate low
// RQ11: Run output high while started and gated
// RQ12: Run output may drive other units' gate
// RQ13: Run pulse optionally stretched to 10 us
// RQ14: Up to eight LAN sessions accepted
// RQ15: Only one session may download
// RQ16: No replies during download, stop accepted
// RQ17: Latest command wins across links
// RQ18: Network settings apply after restart events
// RQ19: Port command stores number, query replies
// RQ20: Commands and replies end in CR LF
// RQ21: Switches invert start, stop, gate, run
// RQ22: Inputs synchronised and edge detected
// RQ23: Simultaneous start and stop: stop wins
module crg_top
   import crg_pkg::*;
#(
   parameter bit WIDE_VARIANT = 1'b0,
   parameter int SESSIONS = MAX_SESSIONS,
   parameter int RUN_MIN = RUN_MIN_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_START,
   input wire logic I_STOP,
   input wire logic I_GATE,
   input wire logic I_GATE_PRESENT,
   input wire crg_inv_t I_INV,
   input wire crg_mode_t I_MODE,
   input wire logic I_STRETCH_EN,
   input wire logic I_MEM_CLEAR,
   input wire logic I_RX_VALID,
   input wire logic [7:0] I_RX_DATA,
   input wire logic [2:0] I_RX_SESSION,
   input wire logic I_RX_USB,
   input wire logic [SESSIONS-1:0] I_SESS_OPEN,
   input wire logic I_RESET_SW_1S,
   input wire logic I_REPLY_REQ,
   output logic O_RUN,
   output logic O_LED,
   output logic O_COUNT_EN,
   output logic O_CAPTURE,
   output logic [14:0] O_MEM_ADDR,
   output logic O_MEM_FULL,
   output logic O_RESTART,
   output logic O_NET_APPLY,
   output logic [15:0] O_PORT,
   output logic O_DL_ACTIVE,
   output logic [2:0] O_DL_OWNER,
   output logic O_REPLY_EN,
   output logic O_PORT_REPLY,
   output logic O_LAST_USB
);

   localparam int MEM_DEPTH = WIDE_VARIANT ? MEM_DEPTH_16CH : MEM_DEPTH_8CH;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   initial begin
      if (SESSIONS < 1 || SESSIONS > MAX_SESSIONS) begin
         $error("SESSIONS out of range");
      end
      if (RUN_MIN < 1 || RUN_MIN > 65535) begin
         $error("RUN_MIN out of range");
      end
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] meta_ff;   // First stage, read only by second stage
   logic [2:0] sync_ff;   // Second stage
   logic [2:0] prev_ff;   // Previous synced value for edges
   logic [2:0] raw_pins;
   logic gate_pin;
   logic [2:0] warm_ff;   // Masks the false edge an inverted idle pin gives after reset

   // RQ7: open gate high
   assign gate_pin = I_GATE_PRESENT ? I_GATE : 1'b1;
   // RQ21: level inversion switches
   assign raw_pins = {gate_pin ^ I_INV.gate, I_STOP ^ I_INV.stop, I_START ^ I_INV.start};

   // RQ22: two-flop sync
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         meta_ff <= 3'b100;
         sync_ff <= 3'b100;
         prev_ff <= 3'b100;
         warm_ff <= 3'b000;
      end else begin
         meta_ff <= raw_pins;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         warm_ff <= {warm_ff[1:0], 1'b1};
      end
   end

   logic start_edge;
   logic stop_edge;
   logic gate_high;
   logic gate_fall;
   // RQ22: rising edge detect on start and stop, falling edge on gate
   assign start_edge = sync_ff[0] & ~prev_ff[0] & warm_ff[2];
   assign stop_edge = sync_ff[1] & ~prev_ff[1] & warm_ff[2];
   assign gate_high = sync_ff[2];
   assign gate_fall = ~sync_ff[2] & prev_ff[2] & warm_ff[2];

   // ----------------------------------------------------------------
   // Host command decoder
   // ----------------------------------------------------------------
   // Commands are ASCII lines: "S"=start, "P"=stop, "R"=restart, "D"=download,
   // "E"=end download, "T<digits>"=port set, "Q"=port query. A line acts
   // only when CR then LF closes it; a short code set keeps the parser tiny.
   logic [7:0] op_ff;     // First byte of the current line
   logic [15:0] num_ff;   // Decimal accumulator
   logic cr_ff;           // Last byte was CR
   logic [2:0] sess_ff;   // Session of the line
   logic usb_ff;          // Link of the line
   logic bad_ff;          // Non-digit in port argument
   logic first_ff;        // Next byte opens a line
   crg_cmd_t cmd;
   logic line_end;

   // RQ20: CR LF terminates a command
   assign line_end = I_RX_VALID & cr_ff & (I_RX_DATA == ASCII_LF);

   // Byte collection
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         op_ff <= 8'h00;
         num_ff <= 16'h0000;
         cr_ff <= 1'b0;
         sess_ff <= 3'h0;
         usb_ff <= 1'b0;
         bad_ff <= 1'b0;
         first_ff <= 1'b1;
      end else if (I_RX_VALID) begin
         cr_ff <= (I_RX_DATA == ASCII_CR);
         if (line_end) begin
            first_ff <= 1'b1;
         end else if (first_ff) begin
            op_ff <= I_RX_DATA;
            num_ff <= 16'h0000;
            bad_ff <= 1'b0;
            sess_ff <= I_RX_SESSION;
            usb_ff <= I_RX_USB;
            first_ff <= 1'b0;
         end else if (I_RX_DATA >= ASCII_0 && I_RX_DATA <= ASCII_9) begin
            // RQ19: decimal port digits
            num_ff <= 16'(num_ff * 16'h000A + 16'(I_RX_DATA - ASCII_0));
         end else if (I_RX_DATA != ASCII_CR) begin
            bad_ff <= 1'b1;
         end
      end
   end

   // Decode on the line terminator
   always_comb begin
      cmd = '0;
      if (line_end) begin
         unique case (op_ff)
            8'h53: cmd.start = 1'b1;
            8'h50: cmd.stop = 1'b1;
            8'h52: cmd.restart = 1'b1;
            8'h44: cmd.dl_begin = 1'b1;
            8'h45: cmd.dl_end = 1'b1;
            8'h54: cmd.port_set = ~bad_ff;
            8'h51: cmd.port_query = 1'b1;
            default: cmd = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Session and download arbitration
   // ----------------------------------------------------------------
   logic sess_ok;
   // RQ14: only open sessions among eight
   assign sess_ok = usb_ff | I_SESS_OPEN[sess_ff];

   logic dl_ff;
   logic [2:0] owner_ff;
   // RQ15: single download owner
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         dl_ff <= 1'b0;
         owner_ff <= 3'h0;
      end else if (cmd.dl_end & sess_ok) begin
         // RQ16: stop accepted mid download, from any link
         dl_ff <= 1'b0;
      end else if (cmd.dl_begin & sess_ok & ~dl_ff) begin
         dl_ff <= 1'b1;
         owner_ff <= sess_ff;
      end else if (dl_ff & ~I_SESS_OPEN[owner_ff]) begin
         // Owner session dropped; release so others may download
         dl_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Run / gate control
   // ----------------------------------------------------------------
   logic started_ff;
   logic go_start;
   logic go_stop;
   // RQ5: host start same as pin
   assign go_start = start_edge | (cmd.start & sess_ok);
   assign go_stop = stop_edge | (cmd.stop & sess_ok);

   // RQ1: start arms counting; RQ2: stop ends it; RQ3: interval between
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         started_ff <= 1'b0;
      end else if (go_stop) begin
         // RQ23: stop wins tie
         started_ff <= 1'b0;
      end else if (go_start) begin
         started_ff <= 1'b1;
      end
   end

   logic run_valid;
   logic count_en;
   // RQ11: run when started and gate high
   assign run_valid = started_ff & gate_high;
   // RQ6: gate low pauses; RQ10: edge mode ignores gate level
   assign count_en = started_ff & (gate_high | (I_MODE == CRG_MODE_GEDGE));

   // Run pulse stretcher
   logic [15:0] hold_ff;
   // RQ13: minimum run width
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         hold_ff <= 16'h0000;
      end else if (run_valid & ~(O_RUN ^ I_INV.run) & I_STRETCH_EN) begin
         hold_ff <= 16'(RUN_MIN - 1);
      end else if (hold_ff != 16'h0000) begin
         hold_ff <= hold_ff - 16'h0001;
      end
   end

   // Registered run, LED and count enable
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         O_RUN <= 1'b0;
         O_LED <= 1'b0;
         O_COUNT_EN <= 1'b0;
      end else begin
         // RQ21: run output inversion
         O_RUN <= (run_valid | (hold_ff != 16'h0000)) ^ I_INV.run;
         O_LED <= run_valid;
         O_COUNT_EN <= count_en;
      end
   end

   // ----------------------------------------------------------------
   // Sample capture addressing
   // ----------------------------------------------------------------
   logic do_cap;
   // RQ8: capture on gate fall while started
   assign do_cap = gate_fall & started_ff & (I_MODE != CRG_MODE_PLAIN) & ~O_MEM_FULL;

   // RQ9: bounded entry count
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         O_MEM_ADDR <= 15'h0000;
         O_MEM_FULL <= 1'b0;
         O_CAPTURE <= 1'b0;
      end else begin
         O_CAPTURE <= do_cap;
         if (I_MEM_CLEAR) begin
            O_MEM_ADDR <= do_cap ? 15'h0001 : 15'h0000;   // A capture in the clear cycle keeps entry 0
            O_MEM_FULL <= 1'b0;
         end else if (do_cap) begin
            O_MEM_ADDR <= O_MEM_ADDR + 15'h0001;
            O_MEM_FULL <= (O_MEM_ADDR == 15'(MEM_DEPTH - 1));
         end
      end
   end

   // ----------------------------------------------------------------
   // Network settings and replies
   // ----------------------------------------------------------------
   logic [15:0] port_new_ff;
   // RQ19: port set stores number; RQ18: applied on restart events
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         port_new_ff <= PORT_RESET;
         O_PORT <= PORT_RESET;
         O_RESTART <= 1'b0;
         O_NET_APPLY <= 1'b0;
      end else begin
         O_RESTART <= cmd.restart & sess_ok;
         O_NET_APPLY <= (cmd.restart & sess_ok) | I_RESET_SW_1S;
         if (cmd.port_set & sess_ok) begin
            port_new_ff <= num_ff;
         end
         if ((cmd.restart & sess_ok) | I_RESET_SW_1S) begin
            O_PORT <= port_new_ff;
         end
      end
   end

   // Reply gating and last-link tracking
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         O_REPLY_EN <= 1'b1;
         O_PORT_REPLY <= 1'b0;
         O_LAST_USB <= 1'b0;
         O_DL_ACTIVE <= 1'b0;
         O_DL_OWNER <= 3'h0;
      end else begin
         // RQ16: silence replies in download
         O_REPLY_EN <= ~dl_ff & I_REPLY_REQ;
         O_PORT_REPLY <= cmd.port_query & sess_ok & ~dl_ff;
         O_DL_ACTIVE <= dl_ff;
         O_DL_OWNER <= owner_ff;
         // RQ17: latest command's link wins
         if (line_end & sess_ok) begin
            O_LAST_USB <= usb_ff;
         end
      end
   end

endmodule

// file: verification/crg_top_assertions.sv
// Concurrent checks on the run/gate control top ports
module crg_top_assertions
   import crg_pkg::*;
#(
   parameter int RUN_MIN = RUN_MIN_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_START,
   input wire logic I_STOP,
   input wire logic I_GATE,
   input wire logic I_GATE_PRESENT,
   input wire crg_inv_t I_INV,
   input wire crg_mode_t I_MODE,
   input wire logic I_STRETCH_EN,
   input wire logic I_RX_VALID,
   input wire logic O_RUN,
   input wire logic O_LED,
   input wire logic O_COUNT_EN,
   input wire logic O_CAPTURE,
   input wire logic O_DL_ACTIVE,
   input wire logic [2:0] O_DL_OWNER,
   input wire logic O_REPLY_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   // Checks that use pos_ok assume default polarity and skip inverted setups
   logic pos_ok;
   assign pos_ok = (I_INV == 4'h0);
   // Length of the present run pulse
   logic [15:0] run_len_ff;
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         run_len_ff <= 16'h0000;
      end else begin
         run_len_ff <= O_RUN ? run_len_ff + 16'h0001 : 16'h0000;
      end
   end
   property p_start;
      ($rose(I_START) && pos_ok && (I_GATE || !I_GATE_PRESENT))
         ##1 (!I_STOP && (I_GATE || !I_GATE_PRESENT))[*4] |-> O_COUNT_EN;
   endproperty
   a_start: assert property (p_start)
      else $error("no count enable after start");
   property p_stop;
      ($rose(I_STOP) && pos_ok) ##1 (!I_START)[*4] |-> !O_COUNT_EN;
   endproperty
   a_stop: assert property (p_stop)
      else $error("count enable after stop");
   property p_pause;
      ($fell(I_GATE) && I_GATE_PRESENT && pos_ok && I_MODE != CRG_MODE_GEDGE)
         ##1 (!I_GATE)[*4] |-> !O_COUNT_EN;
   endproperty
   a_pause: assert property (p_pause)
      else $error("counting with gate low");
   property p_edge;
      (O_COUNT_EN && I_MODE == CRG_MODE_GEDGE && !I_STOP && !I_RX_VALID)[*5] |=> O_COUNT_EN;
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge mode dropped counting");
   property p_run_led;
      (pos_ok && $past(pos_ok) && $past(pos_ok, 2) && !I_STRETCH_EN) |-> O_RUN == O_LED;
   endproperty
   a_run_led: assert property (p_run_led)
      else $error("run and lamp differ");
   property p_stretch;
      ($fell(O_RUN) && I_STRETCH_EN && pos_ok) |-> int'(run_len_ff) >= RUN_MIN;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("run pulse shorter than minimum");
   property p_capture;
      ($fell(I_GATE) && I_GATE_PRESENT && O_COUNT_EN && pos_ok && I_MODE == CRG_MODE_GDATA)
         ##1 (!I_GATE)[*3] |-> O_CAPTURE;
   endproperty
   a_capture: assert property (p_capture)
      else $error("no capture on gate fall");
   property p_owner;
      (O_DL_ACTIVE && $past(O_DL_ACTIVE)) |-> $stable(O_DL_OWNER);
   endproperty
   a_owner: assert property (p_owner)
      else $error("download owner changed");
   property p_quiet;
      O_DL_ACTIVE[*3] |-> !O_REPLY_EN;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("replies during download");
   property p_stop_wins;
      ($rose(I_START) && $rose(I_STOP) && pos_ok && !O_COUNT_EN) |-> ##1 (!O_COUNT_EN)[*6];
   endproperty
   a_stop_wins: assert property (p_stop_wins)
      else $error("start beat a same-cycle stop");
endmodule

bind crg_top crg_top_assertions #(.RUN_MIN(RUN_MIN)) u_crg_top_assertions (.*);

// file: verification/crg_partner.sv
// Model of the trigger sources and host link facing the block
module crg_partner
   import crg_pkg::*;
(
   input wire logic i_clk,
   output logic o_start,
   output logic o_stop,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_start = 1'b0;
      o_stop = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
   end
   // hold 120 ns, then low before the next pulse
   task automatic pulse(input logic [1:0] which);
      @(negedge i_clk);
      o_start = which[0];
      o_stop = which[1];
      repeat (30) @(negedge i_clk);
      o_start = 1'b0;
      o_stop = 1'b0;
      repeat (30) @(negedge i_clk);
   endtask
   // ASCII line ends in CR LF
   task automatic send(input string s);
      for (int i = 0; i < s.len() + 2; i++) begin
         @(negedge i_clk);
         o_rx_valid = 1'b1;
         o_rx_data = (i < s.len()) ? s[i] : ((i == s.len()) ? ASCII_CR : ASCII_LF);
      end
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      // Idle data must not look like the last byte
      o_rx_data = ~o_rx_data;
      repeat (8) @(negedge i_clk);
   endtask
endmodule

// file: verification/count_run_gate_control_bench.sv
// Self-checking bench for the run/gate control block
module count_run_gate_control_bench
   import crg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Short stretch length keeps the run brief
   localparam int RUN_MIN_TB = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic gate = 1'b0;
   logic gate_on = 1'b0;
   crg_inv_t inv = 4'h0;
   crg_mode_t mode = CRG_MODE_PLAIN;
   logic stretch = 1'b0;
   logic [2:0] sess = 3'h0;
   logic usb = 1'b0;
   logic mem_clr = 1'b0;
   logic rst_sw = 1'b0;
   logic reply_req = 1'b1;
   logic [7:0] sess_open = 8'hFF;
   logic restart, net_apply, mem_full;
   logic [14:0] mem_addr;
   logic start, stop, rx_valid, run, led, cnt_en, cap;
   logic dl_act, rep_en, port_rep, last_usb;
   logic [7:0] rx_data;
   logic [2:0] dl_own;
   logic [15:0] port;
   int n_fail = 0;
   int comparisons = 0;
   int n_cap = 0;
   int n_prep = 0;
   int n_rst = 0;
   int n_app = 0;
   int cyc = 0;
   int seed = 64026;
   always #2 clk = ~clk;
   crg_partner u_crg_partner (.i_clk(clk), .o_start(start), .o_stop(stop),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data));
   crg_top #(.RUN_MIN(RUN_MIN_TB)) u_crg_top (.I_CLK_SYS(clk), .I_RESET(rst),
      .I_START(start), .I_STOP(stop), .I_GATE(gate), .I_GATE_PRESENT(gate_on),
      .I_INV(inv), .I_MODE(mode), .I_STRETCH_EN(stretch), .I_MEM_CLEAR(mem_clr),
      .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .I_RX_SESSION(sess), .I_RX_USB(usb),
      .I_SESS_OPEN(sess_open), .I_RESET_SW_1S(rst_sw), .I_REPLY_REQ(reply_req),
      .O_RUN(run), .O_LED(led), .O_COUNT_EN(cnt_en), .O_CAPTURE(cap),
      .O_MEM_ADDR(mem_addr), .O_MEM_FULL(mem_full), .O_RESTART(restart),
      .O_NET_APPLY(net_apply), .O_PORT(port), .O_DL_ACTIVE(dl_act),
      .O_DL_OWNER(dl_own), .O_REPLY_EN(rep_en), .O_PORT_REPLY(port_rep),
      .O_LAST_USB(last_usb));
   // Expected run pin from start state, gate and polarity switch
   function automatic logic exp_run(input logic started, input logic g, input logic iv);
      return (started & g) ^ iv;
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic gate_set(input logic v);
      gate = v;
      repeat (8) @(negedge clk);
   endtask
   task automatic cmd(input string s, input logic [2:0] ss, input logic u);
      sess = ss;
      usb = u;
      u_crg_partner.send(s);
   endtask
   // Pulse counters and hang guard, at the falling edge where outputs are settled
   always @(negedge clk) begin
      cyc++;
      if (cap === 1'b1) n_cap++;
      if (port_rep === 1'b1) n_prep++;
      if (restart === 1'b1) n_rst++;
      if (net_apply === 1'b1) n_app++;
      if (cyc == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      logic [15:0] pr;
      int base;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      // Open gate pin with low level still lets counting run
      u_crg_partner.pulse(2'b01);
      check("count_en", cnt_en, 1'h1);
      check("led", led, 1'h1);
      gate_on = 1'b1;
      gate_set(1'b0);
      check("count_en", cnt_en, 1'h0);
      check("run", run, exp_run(1'h1, 1'h0, 1'h0));
      gate_set(1'b1);
      check("run", run, exp_run(1'h1, 1'h1, 1'h0));
      $display("test pin_start_gate done");
      mode = CRG_MODE_GDATA;
      base = n_cap;
      gate_set(1'b0);
      gate_set(1'b1);
      check("captures", 16'(n_cap - base), 16'h0001);
      check("mem_addr", mem_addr, 16'h0001);
      mode = CRG_MODE_GEDGE;
      gate_set(1'b0);
      check("count_en", cnt_en, 1'h1);
      check("run", run, exp_run(1'h1, 1'h0, 1'h0));
      gate_set(1'b1);
      check("mem_addr", mem_addr, 16'h0002);
      check("mem_full", mem_full, 1'h0);
      mode = CRG_MODE_PLAIN;
      mem_clr = 1'b1;
      @(negedge clk);
      mem_clr = 1'b0;
      @(negedge clk);
      check("mem_addr", mem_addr, 16'h0000);
      u_crg_partner.pulse(2'b10);
      check("count_en", cnt_en, 1'h0);
      $display("test modes_stop done");
      sess_open = 8'hDF;
      cmd("S", 3'h5, 1'b0);
      check("count_en", cnt_en, 1'h0);
      sess_open = 8'hFF;
      cmd("S", 3'($random(seed)), 1'b0);
      check("count_en", cnt_en, 1'h1);
      cmd("P", 3'h0, 1'b1);
      check("count_en", cnt_en, 1'h0);
      check("last_usb", last_usb, 1'h1);
      u_crg_partner.pulse(2'b11);
      check("count_en", cnt_en, 1'h0);
      $display("test host_start_stop done");
      stretch = 1'b1;
      gate_set(1'b0);
      u_crg_partner.pulse(2'b01);
      gate = 1'b1;
      repeat (2) @(negedge clk);
      gate = 1'b0;
      repeat (20) @(negedge clk);
      check("run", run, 1'h1);
      repeat (40) @(negedge clk);
      check("run", run, 1'h0);
      gate_set(1'b1);
      u_crg_partner.pulse(2'b10);
      stretch = 1'b0;
      inv.run = 1'b1;
      repeat (4) @(negedge clk);
      check("run", run, exp_run(1'h0, 1'h1, 1'h1));
      inv = 4'h0;
      repeat (4) @(negedge clk);
      $display("test stretch_invert done");
      pr = 16'($random(seed));
      cmd($sformatf("T%0d", pr), 3'h0, 1'b0);
      check("port", port, PORT_RESET);
      base = n_prep;
      cmd("Q", 3'h0, 1'b0);
      check("port_reply", 16'(n_prep - base), 16'h0001);
      check("last_usb", last_usb, 1'h0);
      cmd("R", 3'h0, 1'b0);
      check("port", port, pr);
      check("restarts", 16'(n_rst), 16'h0001);
      pr = 16'($random(seed));
      cmd($sformatf("T%0d", pr), 3'h2, 1'b0);
      rst_sw = 1'b1;
      @(negedge clk);
      rst_sw = 1'b0;
      repeat (2) @(negedge clk);
      check("port", port, pr);
      check("applies", 16'(n_app), 16'h0002);
      check("restarts", 16'(n_rst), 16'h0001);
      cmd("D", 3'h1, 1'b0);
      check("dl_active", dl_act, 1'h1);
      check("reply_en", rep_en, 1'h0);
      base = n_prep;
      cmd("Q", 3'h3, 1'b0);
      check("port_reply", 16'(n_prep - base), 16'h0000);
      cmd("D", 3'h4, 1'b0);
      check("dl_owner", dl_own, 3'h1);
      cmd("E", 3'h4, 1'b0);
      check("dl_active", dl_act, 1'h0);
      check("reply_en", rep_en, 1'h1);
      $display("test port_download done");
      finish_test();
   end
endmodule
